//--- pseudo_fault_pkg.sv
// Constants, field layouts and state types for the pseudo-fault feature bank
// Contract
// R01: Register only in first record with injection model
// R02: 64-bit read-only memory-mapped view, 64-byte stride
// R03: System register view when select index matches
// R04: Bits 63:31 and 27:13 read zero
// R05: Bit 30 flags restart mode; else control zero
// R06: Bit 29 low: node loads error codes
// R07: Bit 29 high: codes untouched, writable when invalid
// R08: Bit 28 selects access or spontaneous detection
// R09: Bit 12 low: misc-valid set only if written
// R10: Bit 12 high: misc-valid copies control bit; the code sets it to one instead whenever the node writes misc syndrome
// R11: Non-node misc fields writable while misc-valid clear
// R12: Misc control reads one if always set
// R13: Bit 11 low: captured address sets address-valid
// R14: Bit 11 high: address kept, valid from control
// R15: Address record writable only while address-valid clear
// R16: Bit 10 high copies poison control bit
// R17: Bit 9 high copies reported control bit
// R18: Critical flag high copies critical control bit
// R19: Injection state entered when countdown hits zero
// R20: Capability bits fixed, writes ignored
package pseudo_fault_pkg;

  // ************************************
  // Register offsets (byte addresses)
  // ************************************
  localparam logic [11:0] FEATURE_BASE_OFF = 12'h800;
  localparam logic [11:0] RECORD_STRIDE    = 12'h040;
  localparam logic [11:0] CONTROL_OFF      = 12'h010;
  localparam logic [11:0] COUNTDOWN_OFF    = 12'h018;
  localparam logic [11:0] STATUS_OFF       = 12'h020;
  localparam logic [11:0] ADDR_REC_OFF     = 12'h028;
  localparam logic [11:0] MISC_REC_OFF     = 12'h030;

  // ************************************
  // Feature and control bit positions
  // ************************************
  localparam int RESTART_BIT  = 30;
  localparam int SYNDROME_BIT = 29;
  localparam int NO_ACC_BIT   = 28;
  localparam int MISC_BIT     = 12;
  localparam int ADDR_BIT     = 11;
  localparam int POISON_BIT   = 10;
  localparam int FLAGGED_BIT  = 9;
  localparam int CRIT_BIT     = 8;
  localparam int CNT_EN_BIT   = 31;

  // ************************************
  // Status record layout
  // ************************************
  localparam int ST_VALID = 0;
  localparam int ST_MV    = 1;
  localparam int ST_AV    = 2;
  localparam int ST_PN    = 3;
  localparam int ST_ER    = 4;
  localparam int ST_CI    = 5;
  localparam int ST_IMPLEMENTATION_ERROR_CODE_LSB = 8;
  localparam int ST_ARCHITECTURAL_ERROR_CODE_LSB = 16;
  localparam logic [63:0] STATUS_FLAG_MASK = 64'h0000_0000_0000_003F;
  localparam logic [63:0] STATUS_CODE_MASK = 64'h0000_0000_00FF_FF00;

  localparam logic [63:0] FEATURE_RSVD_MASK = 64'hFFFF_FFFF_8FFF_E000;
  localparam logic [63:0] RESET_ZERO64      = 64'h0000_0000_0000_0000;
  localparam logic [1:0]  MODEL_ABSENT      = 2'h0;

  typedef enum logic [1:0] {
    INJ_IDLE  = 2'b01,
    INJ_ARMED = 2'b10
  } inj_state_t;

endpackage

//--- inject_countdown.sv
// Injection countdown counter with optional restart reload
`timescale 1ns/10ps
module inject_countdown
  import pseudo_fault_pkg::*;
#(
  parameter int W = 32
)(
  input  wire logic         core_clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] load_val_i,
  input  wire logic         run_i,
  input  wire logic         restart_i,
  output logic     [W-1:0]  count_o,
  output logic              hit_o
);

  typedef struct packed {
    logic [W-1:0] count;
    logic [W-1:0] reload;
    logic         hit;
  } cnt_state_t;

  cnt_state_t s_q, s_d;

  always_comb
  begin
    s_d     = s_q;
    s_d.hit = 1'b0;
    if (load_i)
    begin
      s_d.count  = load_val_i;
      s_d.reload = load_val_i;
    end
    else if (run_i && s_q.count != '0)
    begin
      s_d.count = s_q.count - 1'b1;
      if (s_q.count == W'(1))
      begin
        s_d.hit = 1'b1; // see R19
        // Restart reloads so injections repeat without software help
        if (restart_i)
          s_d.count = s_q.reload;
      end
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign count_o = s_q.count;
  assign hit_o   = s_q.hit;

endmodule

//--- pseudo_fault_feature_bank.sv
// Pseudo-fault feature register and injected-error recording of one node
`timescale 1ns/10ps
module pseudo_fault_feature_bank
  import pseudo_fault_pkg::*;
#(
  parameter int          REC_NUM        = 0,
  parameter logic        FIRST_RECORD   = 1'b1,
  parameter logic [1:0]  INJ_MODEL      = 2'h1,
  parameter logic        CAP_RESTART    = 1'b1,
  parameter logic        CAP_SYNDROME   = 1'b1,
  parameter logic        CAP_NO_ACCESS  = 1'b0,
  parameter logic        CAP_MISC       = 1'b1,
  parameter logic        CAP_ADDR       = 1'b1,
  parameter logic        CAP_POISON     = 1'b1,
  parameter logic        CAP_FLAGGED    = 1'b1,
  parameter logic        CAP_CRIT       = 1'b1,
  parameter logic        MV_ALWAYS      = 1'b0,
  parameter logic        AV_ALWAYS      = 1'b0,
  parameter logic        NODE_ADDR_CAPT = 1'b1,
  parameter logic [63:0] NODE_MISC_MASK = 64'h0000_0000_0000_00FF,
  parameter logic [7:0]  IMPL_IMPLEMENTATION_ERROR_CODE      = 8'h5A,
  parameter logic [7:0]  IMPL_ARCHITECTURAL_ERROR_CODE      = 8'h0C,
  parameter logic        IMPL_PN        = 1'b0,
  parameter logic        IMPL_ER        = 1'b1,
  parameter logic        IMPL_CI        = 1'b0,
  parameter int          CNT_W          = 32,
  parameter int          SEL_W          = 16
)(
  input  wire logic             core_clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             mm_rd_i,
  input  wire logic             mm_wr_i,
  input  wire logic [11:0]      mm_addr_i,
  input  wire logic [63:0]      mm_wdata_i,
  output logic      [63:0]      mm_rdata_o,
  output logic                  mm_rvalid_o,
  input  wire logic             sysreg_rd_i,
  input  wire logic [SEL_W-1:0] record_select_i,
  output logic      [63:0]      sysreg_rdata_o,
  input  wire logic             comp_access_i,
  input  wire logic [63:0]      fault_addr_i,
  input  wire logic [63:0]      misc_syndrome_i,
  output logic                  inject_state_o,
  output logic                  inject_event_o
);

  // ************************************
  // Fixed feature word
  // ************************************
  localparam logic PRESENT = (INJ_MODEL != MODEL_ABSENT) && FIRST_RECORD; // see R01
  localparam logic [11:0] FEAT_OFF = FEATURE_BASE_OFF + 12'(RECORD_STRIDE * REC_NUM); // see R02

  logic [63:0] feature_w;
  always_comb
  begin
    feature_w = RESET_ZERO64;
    feature_w[RESTART_BIT]  = CAP_RESTART;
    feature_w[SYNDROME_BIT] = CAP_SYNDROME;
    feature_w[NO_ACC_BIT]   = CAP_NO_ACCESS;
    feature_w[MISC_BIT]     = CAP_MISC;
    feature_w[ADDR_BIT]     = CAP_ADDR;
    feature_w[POISON_BIT]   = CAP_POISON;
    feature_w[FLAGGED_BIT]  = CAP_FLAGGED;
    feature_w[CRIT_BIT]     = CAP_CRIT;
    feature_w = PRESENT ? (feature_w & ~FEATURE_RSVD_MASK) : RESET_ZERO64; // see R01 see R04 see R20
  end

  // Control bits that exist are read/write, except always-set misc/address bits which read one; others read zero
  localparam logic [63:0] CTL_RW_MASK =
    (64'(CAP_RESTART) << RESTART_BIT) | (64'(CAP_MISC && !MV_ALWAYS) << MISC_BIT) |
    (64'(CAP_ADDR && !AV_ALWAYS) << ADDR_BIT) | (64'(CAP_POISON) << POISON_BIT) |
    (64'(CAP_FLAGGED) << FLAGGED_BIT) | (64'(CAP_CRIT) << CRIT_BIT) | (64'h1 << CNT_EN_BIT);
  localparam logic [63:0] CTL_RAO_MASK =
    (64'(CAP_MISC && MV_ALWAYS) << MISC_BIT) | (64'(CAP_ADDR && AV_ALWAYS) << ADDR_BIT);

  // ************************************
  // State
  // ************************************
  typedef struct packed {
    inj_state_t  fault_insertion_model;
    logic [63:0] ctl;
    logic [63:0] status;
    logic [63:0] addr_rec;
    logic [63:0] misc_rec;
    logic [63:0] mm_rdata;
    logic        mm_rvalid;
    logic [63:0] sys_rdata;
    logic        event_p;
  } bank_state_t;

  bank_state_t s_q, s_d;

  logic [CNT_W-1:0] count_w;
  logic             hit_w;
  logic             cnt_load_w;
  logic [63:0]      ctl_view_w;
  logic             fire_w;

  assign cnt_load_w = mm_wr_i && mm_addr_i == COUNTDOWN_OFF;
  assign ctl_view_w = (s_q.ctl & CTL_RW_MASK) | CTL_RAO_MASK; // see R05 see R12

  inject_countdown #(
    .W          (CNT_W)
  ) u_countdown (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .load_i     (cnt_load_w),
    .load_val_i (mm_wdata_i[CNT_W-1:0]),
    .run_i      (s_q.ctl[CNT_EN_BIT]),
    .restart_i  (ctl_view_w[RESTART_BIT]),  // see R05
    .count_o    (count_w),
    .hit_o      (hit_w)
  );

  // Detection faked spontaneously or on the next component access
  assign fire_w = s_q.fault_insertion_model == INJ_ARMED && (CAP_NO_ACCESS || comp_access_i); // see R08

  // ************************************
  // Next-state logic
  // ************************************
  always_comb
  begin
    logic [63:0] st;
    logic        node_misc;
    st        = s_q.status;
    // Node records misc syndrome only when it has some, so MV is not forced
    node_misc = (misc_syndrome_i & NODE_MISC_MASK) != RESET_ZERO64;
    s_d           = s_q;
    s_d.event_p   = 1'b0;
    s_d.mm_rvalid = 1'b0;

    // Software writes; capability word itself takes no write
    if (mm_wr_i)
    begin
      case (mm_addr_i)
        CONTROL_OFF:
          s_d.ctl = mm_wdata_i & CTL_RW_MASK;
        STATUS_OFF:
        begin
          st = st & ~(mm_wdata_i & STATUS_FLAG_MASK);
          if (CAP_SYNDROME && !s_q.status[ST_VALID])
            st = (st & ~STATUS_CODE_MASK) | (mm_wdata_i & STATUS_CODE_MASK); // see R07
        end
        ADDR_REC_OFF:
          if (!s_q.status[ST_AV])
            s_d.addr_rec = mm_wdata_i; // see R15
        MISC_REC_OFF:
          if (!s_q.status[ST_MV])
            s_d.misc_rec = (s_q.misc_rec & NODE_MISC_MASK) | (mm_wdata_i & ~NODE_MISC_MASK); // see R11
        default:
          s_d.ctl = s_q.ctl;
      endcase
    end

    // Injection state machine
    case (s_q.fault_insertion_model)
      INJ_IDLE:
        if (hit_w)
          s_d.fault_insertion_model = INJ_ARMED; // see R19
      INJ_ARMED:
        if (fire_w)
          s_d.fault_insertion_model = INJ_IDLE;
      default:
        s_d.fault_insertion_model = INJ_IDLE;
    endcase

    // Recording beats a same-cycle software clear
    if (fire_w)
    begin
      s_d.event_p   = 1'b1;
      st[ST_VALID]  = 1'b1;
      if (!CAP_SYNDROME)
      begin
        st[ST_IMPLEMENTATION_ERROR_CODE_LSB +: 8] = IMPL_IMPLEMENTATION_ERROR_CODE; // see R06
        st[ST_ARCHITECTURAL_ERROR_CODE_LSB +: 8] = IMPL_ARCHITECTURAL_ERROR_CODE; // see R06
      end
      if (node_misc)
      begin
        s_d.misc_rec = (s_d.misc_rec & ~NODE_MISC_MASK) | (misc_syndrome_i & NODE_MISC_MASK);
        st[ST_MV]    = 1'b1; // see R09 see R10
      end
      else if (CAP_MISC)
        st[ST_MV] = ctl_view_w[MISC_BIT]; // see R10
      if (CAP_ADDR)
        st[ST_AV] = ctl_view_w[ADDR_BIT]; // see R14
      else if (NODE_ADDR_CAPT)
      begin
        s_d.addr_rec = fault_addr_i; // see R13
        st[ST_AV]    = 1'b1;         // see R13
      end
      st[ST_PN] = CAP_POISON  ? ctl_view_w[POISON_BIT]  : IMPL_PN; // see R16
      st[ST_ER] = CAP_FLAGGED ? ctl_view_w[FLAGGED_BIT] : IMPL_ER; // see R17
      st[ST_CI] = CAP_CRIT    ? ctl_view_w[CRIT_BIT]    : IMPL_CI; // see R18
    end
    s_d.status = st;

    // Read views
    if (mm_rd_i)
    begin
      s_d.mm_rvalid = 1'b1;
      case (mm_addr_i)
        FEAT_OFF:      s_d.mm_rdata = feature_w; // see R02
        CONTROL_OFF:   s_d.mm_rdata = ctl_view_w;
        COUNTDOWN_OFF: s_d.mm_rdata = 64'(count_w);
        STATUS_OFF:    s_d.mm_rdata = s_q.status;
        ADDR_REC_OFF:  s_d.mm_rdata = s_q.addr_rec;
        MISC_REC_OFF:  s_d.mm_rdata = s_q.misc_rec;
        default:       s_d.mm_rdata = RESET_ZERO64;
      endcase
    end
    if (sysreg_rd_i)
      s_d.sys_rdata = (record_select_i == SEL_W'(REC_NUM)) ? feature_w : RESET_ZERO64; // see R03
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      s_q     <= '0;
      s_q.fault_insertion_model <= INJ_IDLE;
    end
    else
      s_q <= s_d;
  end

  assign mm_rdata_o     = s_q.mm_rdata;
  assign mm_rvalid_o    = s_q.mm_rvalid;
  assign sysreg_rdata_o = s_q.sys_rdata;
  // One-hot code: bit 1 alone marks the armed state
  assign inject_state_o = s_q.fault_insertion_model[1];
  assign inject_event_o = s_q.event_p;

  // ************************************
  // Assertions
  // ************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  AST_FEAT_READ: assert property (mm_rd_i && mm_addr_i == FEAT_OFF |=> // see R02
    mm_rvalid_o && mm_rdata_o == feature_w) else $error("feature read wrong");
  AST_ABSENT_ZERO: assert property (mm_rd_i && mm_addr_i == FEAT_OFF && !PRESENT |=> // see R01
    mm_rdata_o == RESET_ZERO64) else $error("absent feature not zero");
  AST_SYS_VIEW: assert property (sysreg_rd_i && record_select_i == SEL_W'(REC_NUM) |=> // see R03
    sysreg_rdata_o == feature_w) else $error("sysreg view wrong");
  AST_RSVD_ZERO: assert property (mm_rvalid_o && $past(mm_addr_i) == FEAT_OFF |-> // see R04
    (mm_rdata_o & FEATURE_RSVD_MASK) == RESET_ZERO64) else $error("reserved bit set");
  AST_RESTART_CTL: assert property (!CAP_RESTART |-> !ctl_view_w[RESTART_BIT]) // see R05
    else $error("restart control without feature");
  AST_CODES: assert property (fire_w && !CAP_SYNDROME |=> // see R06
    s_q.status[ST_IMPLEMENTATION_ERROR_CODE_LSB +: 8] == IMPL_IMPLEMENTATION_ERROR_CODE) else $error("error code not loaded");
  AST_CODES_KEPT: assert property (fire_w && CAP_SYNDROME && !(mm_wr_i && mm_addr_i == STATUS_OFF) |=> // see R07
    $stable(s_q.status[ST_ARCHITECTURAL_ERROR_CODE_LSB +: 8])) else $error("error code changed");
  AST_SPONT: assert property (s_q.fault_insertion_model == INJ_ARMED && CAP_NO_ACCESS |=> inject_event_o) // see R08
    else $error("spontaneous detection missing");
  AST_ARM: assert property (hit_w && s_q.fault_insertion_model == INJ_IDLE |=> inject_state_o) // see R19
    else $error("countdown zero not armed");
  AST_ADDR_LOCK: assert property (s_q.status[ST_AV] && !fire_w |=> $stable(s_q.addr_rec)) // see R15
    else $error("address changed while valid");
  AST_MISC_LOCK: assert property (s_q.status[ST_MV] && !fire_w |=> $stable(s_q.misc_rec)) // see R11
    else $error("misc changed while valid");
  AST_POISON: assert property (fire_w && CAP_POISON |=> s_q.status[ST_PN] == $past(ctl_view_w[POISON_BIT])) // see R16
    else $error("poison not copied");
  AST_FLAGGED: assert property (fire_w && CAP_FLAGGED |=> s_q.status[ST_ER] == $past(ctl_view_w[FLAGGED_BIT])) // see R17
    else $error("reported flag not copied");
  AST_CRIT: assert property (fire_w && CAP_CRIT |=> s_q.status[ST_CI] == $past(ctl_view_w[CRIT_BIT])) // see R18
    else $error("critical flag not copied");
  AST_MV_SET: assert property (fire_w && (misc_syndrome_i & NODE_MISC_MASK) != RESET_ZERO64 |=> // see R09
    s_q.status[ST_MV]) else $error("misc valid not set");
  AST_MV_COPY: assert property (fire_w && CAP_MISC && (misc_syndrome_i & NODE_MISC_MASK) == RESET_ZERO64 |=> // see R10
    s_q.status[ST_MV] == $past(ctl_view_w[MISC_BIT])) else $error("misc valid not copied");
  AST_MISC_RAO: assert property (mm_rd_i && mm_addr_i == CONTROL_OFF && CAP_MISC && MV_ALWAYS |=> // see R12
    mm_rdata_o[MISC_BIT]) else $error("misc control not read as one");
  AST_ADDR_CAPT: assert property (fire_w && !CAP_ADDR && NODE_ADDR_CAPT |=> // see R13
    s_q.addr_rec == $past(fault_addr_i) && s_q.status[ST_AV]) else $error("address not captured");
  AST_ADDR_KEPT: assert property (fire_w && CAP_ADDR && !(mm_wr_i && mm_addr_i == ADDR_REC_OFF) |=> // see R14
    $stable(s_q.addr_rec)) else $error("address record changed by injection");
  AST_AV_COPY: assert property (fire_w && CAP_ADDR |=> s_q.status[ST_AV] == $past(ctl_view_w[ADDR_BIT])) // see R14
    else $error("address valid not copied");
  AST_ARMED_HOLD: assert property (inject_state_o && !CAP_NO_ACCESS && !comp_access_i |=> // see R08
    inject_state_o && !inject_event_o) else $error("detection without access");
  AST_FIRE_ARMED: assert property (inject_event_o |-> $past(inject_state_o)) // see R19
    else $error("injection outside fault injection state");
  AST_NO_RESTART: assert property (hit_w && !$past(ctl_view_w[RESTART_BIT]) |-> count_w == '0) // see R05
    else $error("counter reloaded without restart");
  AST_RESTART: assert property (hit_w && $past(ctl_view_w[RESTART_BIT]) |-> count_w != '0) // see R05
    else $error("counter not reloaded in restart mode");
  AST_RVALID_ONLY: assert property (!mm_rd_i |=> !mm_rvalid_o) // see R02
    else $error("read answer without read");
  AST_SYS_OTHER: assert property (sysreg_rd_i && record_select_i != SEL_W'(REC_NUM) |=> // see R03
    sysreg_rdata_o == RESET_ZERO64) else $error("sysreg view of other record not zero");
  AST_SET_WINS: assert property (fire_w |=> s_q.status[ST_VALID])
    else $error("recording lost to status clear");

  // ************************************
  // Coverage
  // ************************************
  COV_ARM_FIRE: cover property (hit_w ##[1:20] inject_event_o);
  COV_FEAT_READ: cover property (mm_rd_i && mm_addr_i == FEAT_OFF);
  COV_SYS_READ: cover property (sysreg_rd_i && record_select_i == SEL_W'(REC_NUM));
  COV_RESTART: cover property (hit_w && ctl_view_w[RESTART_BIT]);
  COV_SPONT: cover property (inject_state_o && CAP_NO_ACCESS);

endmodule

//--- pseudo_fault_feature_bank_bench.sv
// Self-checking bench for the pseudo-fault feature bank
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; $display("wrong value %s expected %h seen %h", nm, e, g); end end
module pseudo_fault_feature_bank_bench;
  import pseudo_fault_pkg::*;

  // ************************************
  // Signals and model state
  // ************************************
  localparam logic [63:0] NODE_MASK = 64'h0000_0000_0000_00FF;
  localparam logic [63:0] FEAT_EXP  = 64'h0000_0000_6000_1F00;
  logic        core_clk_i      = 1'b0;
  logic        sys_rst_i       = 1'b1;
  logic        mm_rd_i         = 1'b0;
  logic        mm_wr_i         = 1'b0;
  logic [11:0] mm_addr_i       = 12'h000;
  logic [63:0] mm_wdata_i      = 64'h0;
  logic [63:0] mm_rdata_o;
  logic        mm_rvalid_o;
  logic        sysreg_rd_i     = 1'b0;
  logic [15:0] record_select_i = 16'h0000;
  logic [63:0] sysreg_rdata_o;
  logic        comp_access_i   = 1'b0;
  logic [63:0] fault_addr_i    = 64'h0;
  logic [63:0] misc_syndrome_i = 64'h0;
  logic        inject_state_o;
  logic        inject_event_o;
  logic        ev_b_w;
  int          ev_b      = 0;
  logic [63:0] rdata_b;
  logic [63:0] rd_v;
  logic [63:0] ctl;
  logic [63:0] st_e;
  logic [63:0] addr_m;
  logic [63:0] misc_m;
  logic [63:0] v;
  logic        mv;
  logic        av;
  int          error_cnt = 0;
  int          checked   = 0;
  int          cycles    = 0;

  pseudo_fault_feature_bank #(.NODE_MISC_MASK(NODE_MASK)) u_pseudo_fault_feature_bank (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .mm_rd_i(mm_rd_i), .mm_wr_i(mm_wr_i),
    .mm_addr_i(mm_addr_i), .mm_wdata_i(mm_wdata_i), .mm_rdata_o(mm_rdata_o), .mm_rvalid_o(mm_rvalid_o),
    .sysreg_rd_i(sysreg_rd_i), .record_select_i(record_select_i), .sysreg_rdata_o(sysreg_rdata_o),
    .comp_access_i(comp_access_i), .fault_addr_i(fault_addr_i), .misc_syndrome_i(misc_syndrome_i),
    .inject_state_o(inject_state_o), .inject_event_o(inject_event_o));

  // Second node: no feature word, spontaneous detection, forced misc control, node-captured address
  pseudo_fault_feature_bank #(.INJ_MODEL(MODEL_ABSENT), .CAP_NO_ACCESS(1'b1), .MV_ALWAYS(1'b1),
    .CAP_ADDR(1'b0)) u_pseudo_fault_feature_bank_absent (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .mm_rd_i(mm_rd_i), .mm_wr_i(mm_wr_i),
    .mm_addr_i(mm_addr_i), .mm_wdata_i(mm_wdata_i), .mm_rdata_o(rdata_b), .mm_rvalid_o(),
    .sysreg_rd_i(sysreg_rd_i), .record_select_i(record_select_i), .sysreg_rdata_o(),
    .comp_access_i(comp_access_i), .fault_addr_i(fault_addr_i), .misc_syndrome_i(misc_syndrome_i),
    .inject_state_o(), .inject_event_o(ev_b_w));

  always @(posedge core_clk_i)
  begin
    if (ev_b_w === 1'b1)
      ev_b <= ev_b + 1;
  end

  initial
  begin
    forever #25 core_clk_i = ~core_clk_i;
  end

  // ************************************
  // Tasks
  // ************************************
  task automatic close_out();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Hang guard, well above the hundred or so cycles the tests need
  always @(posedge core_clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      error_cnt++;
      close_out();
    end
  end

  task automatic mm_write(input logic [11:0] a, input logic [63:0] d);
    @(posedge core_clk_i);
    #1;
    mm_wr_i    = 1'b1;
    mm_addr_i  = a;
    mm_wdata_i = d;
    @(posedge core_clk_i);
    #1;
    mm_wr_i = 1'b0;
  endtask

  task automatic mm_read(input logic [11:0] a, output logic [63:0] d);
    @(posedge core_clk_i);
    #1;
    mm_rd_i   = 1'b1;
    mm_addr_i = a;
    @(posedge core_clk_i);
    #1;
    mm_rd_i = 1'b0;
    `CHK("read answer", 1'b1, mm_rvalid_o)
    d = mm_rdata_o;
  endtask

  task automatic sys_read(input logic [15:0] sel, output logic [63:0] d);
    @(posedge core_clk_i);
    #1;
    sysreg_rd_i     = 1'b1;
    record_select_i = sel;
    @(posedge core_clk_i);
    #1;
    sysreg_rd_i = 1'b0;
    @(posedge core_clk_i);
    #1;
    d = sysreg_rdata_o;
  endtask

  // ************************************
  // Main sequence
  // ************************************
  initial
  begin
    void'($urandom(52));
    repeat (10) @(posedge core_clk_i);
    #1;
    sys_rst_i = 1'b0;
    mm_read(FEATURE_BASE_OFF, rd_v);
    `CHK("feature", FEAT_EXP, rd_v)
    `CHK("absent feature", RESET_ZERO64, rdata_b)
    v = {$urandom, $urandom};
    mm_write(FEATURE_BASE_OFF, v);
    mm_read(FEATURE_BASE_OFF, rd_v);
    `CHK("feature after write", FEAT_EXP, rd_v)
    sys_read(16'h0000, rd_v);
    `CHK("sysreg feature", FEAT_EXP, rd_v)
    sys_read(16'(1 + $urandom_range(0, 500)), rd_v);
    `CHK("sysreg other record", RESET_ZERO64, rd_v)
    mm_read(12'h840, rd_v);
    `CHK("next record slot", RESET_ZERO64, rd_v)
    addr_m = 64'h0;
    misc_m = 64'h0;
    // Round 0: node writes no misc syndrome; round 1: it does
    for (int r = 0; r < 2; r++)
    begin
      mm_write(STATUS_OFF, STATUS_FLAG_MASK);
      addr_m = {$urandom, $urandom};
      mm_write(ADDR_REC_OFF, addr_m);
      st_e = 64'($urandom) & STATUS_CODE_MASK;
      mm_write(STATUS_OFF, st_e);
      ctl = (64'($urandom) & 64'h0000_0000_0000_1F00) | 64'h0000_0000_8000_0000;
      misc_syndrome_i = (r == 0) ? 64'h0 : 64'($urandom_range(1, 255));
      fault_addr_i = {$urandom, $urandom};
      mm_write(COUNTDOWN_OFF, 64'($urandom_range(1, 4)));
      mm_write(CONTROL_OFF, ctl);
      for (int i = 0; i < 20 && inject_state_o !== 1'b1; i++)
      begin
        @(posedge core_clk_i);
        #1;
      end
      `CHK("inject state", 1'b1, inject_state_o)
      repeat (3) @(posedge core_clk_i);
      #1;
      `CHK("no access no record", 1'b0, inject_event_o)
      `CHK("spontaneous events", r + 1, ev_b)
      comp_access_i = 1'b1;
      for (int i = 0; i < 5 && inject_event_o !== 1'b1; i++)
      begin
        @(posedge core_clk_i);
        #1;
      end
      `CHK("inject event", 1'b1, inject_event_o)
      comp_access_i = 1'b0;
      mv = (misc_syndrome_i[7:0] != 8'h00) | ctl[12];
      av = ctl[11];
      st_e = st_e | 64'h1 | (64'(mv) << 1) | (64'(av) << 2) | (64'(ctl[10]) << 3) | (64'(ctl[9]) << 4)
           | (64'(ctl[8]) << 5);
      mm_read(STATUS_OFF, rd_v);
      `CHK("status", st_e, rd_v)
      mm_read(CONTROL_OFF, rd_v);
      `CHK("control flags", ctl & 64'h0000_0000_0000_1F00, rd_v & 64'h0000_0000_0000_1F00)
      `CHK("forced misc control", 1'b1, rdata_b[12])
      mm_read(ADDR_REC_OFF, rd_v);
      `CHK("address kept", addr_m, rd_v)
      `CHK("node address", fault_addr_i, rdata_b)
      v = {$urandom, $urandom};
      mm_write(ADDR_REC_OFF, v);
      if (!av)
        addr_m = v;
      mm_read(ADDR_REC_OFF, rd_v);
      `CHK("address write", addr_m, rd_v)
      v = {$urandom, $urandom};
      mm_write(MISC_REC_OFF, v);
      if (!mv)
        misc_m = v & ~NODE_MASK;
      mm_read(MISC_REC_OFF, rd_v);
      `CHK("misc write", misc_m, rd_v & ~NODE_MASK)
    end
    // Restart mode: one countdown load gives repeated injections
    mm_write(CONTROL_OFF, 64'h0000_0000_C000_0000);
    mm_write(COUNTDOWN_OFF, 64'(2 + $urandom_range(0, 2)));
    mm_read(CONTROL_OFF, rd_v);
    `CHK("restart control", 1'b1, rd_v[30])
    for (int k = 0; k < 2; k++)
    begin
      for (int i = 0; i < 20 && inject_state_o !== 1'b1; i++)
      begin
        @(posedge core_clk_i);
        #1;
      end
      `CHK("restart arm", 1'b1, inject_state_o)
      comp_access_i = 1'b1;
      for (int i = 0; i < 5 && inject_event_o !== 1'b1; i++)
      begin
        @(posedge core_clk_i);
        #1;
      end
      `CHK("restart event", 1'b1, inject_event_o)
      comp_access_i = 1'b0;
    end
    close_out();
  end
endmodule
